/* dv/flash_ready_status_power_control_test.sv */
/*
 * flash_ready_status_power_control_test: self-checking bench of the controller.
 * Assumes the flash model on the pin side and an APB master here.
 */
`timescale 1ns/1ns
module flash_ready_status_power_control_test import frspc_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, rb_n;
    logic supply_good = 1'b0;
    logic prog_ok = 1'b1;
    frspc_pins_s pins;
    logic [7:0] dq_i, model_dq;
    logic [31:0] r;
    logic e;
    logic [19:0] a;
    logic [7:0] d;
    int bad_count = 0;
    int checks_done = 0;

    assign dq_i = pins.dq_oe_n ? model_dq : pins.dq_o;

    frspc_ctrl #(.WAKE_R(3), .WAKE_W(3)) i_frspc_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .pins(pins),
        .dq_i(dq_i), .ready_busy_n(rb_n), .supply_good(supply_good));
    frspc_flash_model i_frspc_flash_model (.pclk(pclk), .pins(pins), .bus(dq_i),
        .prog_supply_ok(prog_ok), .dq_out(model_dq), .ready_busy_n(rb_n));

    function automatic logic [7:0] exp_byte(logic [19:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5A;
    endfunction : exp_byte

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task check(input string msg, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // poll a register bit until it shows the wanted value
    task poll(input logic [7:0] ad, input int idx, input logic val);
        for (int i = 0; i < 3000; i++) begin
            apb(1'b0, ad, 32'h0);
            if (r[idx] === val) break;
        end
        if (r[idx] !== val) begin
            bad_count++;
            $display("MISMATCH %0t poll limit reached", $time);
        end
    endtask : poll

    task two_step(input logic [19:0] x, input logic [7:0] v);
        apb(1'b1, OFS_ADDR, {12'h0, x});
        apb(1'b1, OFS_DATA, {24'h0, v});
        apb(1'b1, OFS_CMD, 32'h00004002);
    endtask : two_step

    initial begin
        forever #10 pclk = ~pclk;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'hDDFF));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check("rp low without supply", pins.rp_n, 1'b0);
        supply_good <= 1'b1;
        poll(OFS_STAT, 2, 1'b1);
        check("rp after supply", r[2], 1'b1);
        apb(1'b0, OFS_IRQ, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped err", e, 1'b1);
        check("unmapped data", r, 32'h0);
        apb(1'b1, OFS_MASK, 32'h0000000F);
        for (int k = 0; k < 3; k++) begin
            a = 20'($urandom);
            d = 8'($urandom);
            two_step(a, d);
            if (k == 0) apb(1'b1, OFS_CMD, 32'h00000000);
            poll(OFS_STAT, 0, 1'b0);
            check("programmed byte", i_frspc_flash_model.prog_data, d);
            check("irq level", irq, 1'b1);
            apb(1'b0, OFS_IRQ, 32'h0);
            check("done and ready", r & 32'h3, 32'h3);
            if (k == 0) check("reject", r[3], 1'b1);
            apb(1'b1, OFS_DATA, 32'h000000FF);
            apb(1'b1, OFS_CMD, 32'h00000001);
            poll(OFS_STAT, 0, 1'b0);
            if (k == 2) apb(1'b1, OFS_MASK, 32'h0);
            apb(1'b1, OFS_CMD, 32'h00000000);
            poll(OFS_STAT, 0, 1'b0);
            apb(1'b0, OFS_DATA, 32'h0);
            check("array read", r, {24'h0, exp_byte(a)});
        end
        check("masked irq", irq, 1'b0);
        apb(1'b0, OFS_IRQ, 32'h0);
        check("masked done kept", r[0], 1'b1);
        apb(1'b1, OFS_MASK, 32'h0000000F);
        two_step(a, 8'h3C);
        poll(OFS_STAT, 1, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        apb(1'b0, OFS_STAT, 32'h0);
        check("rp dropped", r[2], 1'b0);
        check("queue cleared", r[0], 1'b0);
        apb(1'b0, OFS_IRQ, 32'h0);
        check("abort flag", r[2], 1'b1);
        apb(1'b1, OFS_CTRL, 32'h00000000);
        poll(OFS_STAT, 2, 1'b1);
        d = 8'($urandom);
        two_step(a, d);
        poll(OFS_STAT, 0, 1'b0);
        check("reissued byte", i_frspc_flash_model.prog_data, d);
        prog_ok <= 1'b0;
        two_step(a, d);
        poll(OFS_STAT, 0, 1'b0);
        apb(1'b1, OFS_CMD, 32'h00000000);
        poll(OFS_STAT, 0, 1'b0);
        apb(1'b0, OFS_DATA, 32'h0);
        check("write supply error", r, 32'h00000098);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        apb(1'b1, OFS_CTRL, 32'h00000000);
        poll(OFS_STAT, 2, 1'b1);
        apb(1'b1, OFS_CMD, 32'h00002002);
        poll(OFS_STAT, 0, 1'b0);
        apb(1'b1, OFS_CMD, 32'h00000000);
        poll(OFS_STAT, 0, 1'b0);
        apb(1'b0, OFS_DATA, 32'h0);
        check("erase error after clear", r, 32'h000000A8);
        wrap_up();
    end
endmodule : flash_ready_status_power_control_test

/* dv/frspc_flash_model.sv */
/*
 * frspc_flash_model: behavioural byte-wide flash on the controller's pins.
 * Assumes registered pins from the controller and a resolved data bus.
 */
`timescale 1ns/1ns
module frspc_flash_model import frspc_pkg::*; #(
    parameter int BUSY_CYC = 40,
    parameter int ABORT_CYC = 4,
    parameter logic [7:0] SETUP_CMD = 8'h40,
    parameter logic [7:0] ARRAY_CMD = 8'hFF,
    parameter logic [7:0] ERASE_CMD = 8'h20
) (
    // clock for internal timing
    input wire logic pclk,
    // pins from the controller
    input wire frspc_pins_s pins,
    input wire logic [7:0] bus,
    // program supply state
    input wire logic prog_supply_ok,
    // outputs to the controller
    output logic [7:0] dq_out,
    output logic ready_busy_n
);
    logic armed = 1'b0;
    logic erase_op = 1'b0;
    logic array_mode = 1'b1;
    logic [7:0] stat = 8'h80;
    logic [7:0] last = 8'h00;
    logic [7:0] prog_data = 8'h00;
    int busy = 0;
    int ab = 0;
    logic rd_en;

    function automatic logic [7:0] arr(logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : arr

    // command latch at the end of a write strobe only
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.rp_n) begin
            if (armed) begin
                armed = 1'b0;
                if (!prog_supply_ok) begin
                    stat = stat | 8'h08 | (erase_op ? 8'h20 : 8'h10);
                end else begin
                    busy = BUSY_CYC;
                    prog_data = bus;
                end
            end else if (bus == SETUP_CMD || bus == ERASE_CMD) begin
                armed = 1'b1;
                erase_op = (bus == ERASE_CMD);
                array_mode = 1'b0;
            end else if (bus == ARRAY_CMD) begin
                array_mode = 1'b1;
            end
        end
    end

    // power-down entry aborts and clears
    always @(negedge pins.rp_n) begin
        if (busy > 0) begin
            ab = ABORT_CYC;
        end
        busy = 0;
        armed = 1'b0;
        stat = 8'h80;
        array_mode = 1'b1;
    end

    always @(posedge pclk) begin
        if (busy > 0) begin
            busy--;
        end
        if (ab > 0) begin
            ab--;
        end
    end

    assign ready_busy_n = (busy == 0 && ab == 0);
    assign rd_en = !pins.ce_n && !pins.oe_n && pins.rp_n;
    // released bus shows the inverse of the last value
    assign dq_out = rd_en ? (array_mode ? arr(pins.addr) : stat) : ~last;

    always @(posedge pclk) begin
        if (rd_en) begin
            last <= dq_out;
        end
    end
endmodule : frspc_flash_model

/* verilog/frspc_ctrl.sv */
/*
 * frspc_ctrl: APB-programmed controller driving a byte-wide flash over
 * its chip select, output enable, write enable and power-down pins.
 * Assumes the pin struct is resolved to wires by the surroundings.
 */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
module frspc_ctrl import frspc_pkg::*; #(
    parameter int WAKE_R = WAKE_READ_CYC,
    parameter int WAKE_W = WAKE_WRITE_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // flash pins
    output frspc_pins_s pins,
    input wire logic [7:0] dq_i,
    input wire logic ready_busy_n,
    input wire logic supply_good
);
    frspc_state_e st_q;
    frspc_pins_s pins_q;
    logic [7:0] dq_s;
    logic rdy_s;
    logic good_s;
    logic pwr_down_q;
    logic [AW-1:0] addr_q;
    logic [7:0] data_q;
    logic [7:0] rdata_q;
    logic [7:0] setup_q;
    logic [1:0] op_q;
    logic pend_q;
    logic second_q;
    logic rdy_d1_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] wake_q;
    logic [NIRQ-1:0] stat_q;
    logic [NIRQ-1:0] mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [NIRQ-1:0] ev;
    logic [NIRQ-1:0] kept;
    logic rp_d;
    logic wake_ok;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    function automatic logic mapped(input logic [7:0] a);
        return hit(a, OFS_CTRL) || hit(a, OFS_ADDR) || hit(a, OFS_DATA) ||
            hit(a, OFS_CMD) || hit(a, OFS_STAT) || hit(a, OFS_IRQ) || hit(a, OFS_MASK);
    endfunction : mapped

    frspc_sync #(.W(10), .INIT(10'h002)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({dq_i, ready_busy_n, supply_good}),
        .q({dq_s, rdy_s, good_s})
    );

    assign acc = psel && penable && pready_q;
    assign wr_acc = acc && pwrite && mapped(paddr);
    assign rd_acc = acc && !pwrite && mapped(paddr);
    assign rp_d = good_s && !pwr_down_q;
    assign wake_ok = (op_q == OP_READ) ? (wake_q >= CW'(WAKE_R)) :
        (wake_q >= CW'(WAKE_W));

    // apb answer, one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped(paddr);
            if (psel && penable && !pready_q && !pwrite) begin
                case (paddr)
                    OFS_CTRL: prdata_q <= {31'h0, pwr_down_q};
                    OFS_ADDR: prdata_q <= {{(32-AW){1'b0}}, addr_q};
                    OFS_DATA: prdata_q <= {24'h0, rdata_q};
                    OFS_CMD: prdata_q <= {16'h0, setup_q, 6'h0, op_q};
                    OFS_STAT: prdata_q <= {28'h0, wake_ok, pins_q.rp_n, rdy_s,
                        st_q != ST_IDLE || pend_q};
                    OFS_IRQ: prdata_q <= {{(32-NIRQ){1'b0}}, stat_q};
                    OFS_MASK: prdata_q <= {{(32-NIRQ){1'b0}}, mask_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_down_q <= 1'b0;
            addr_q <= '0;
            data_q <= 8'h00;
            mask_q <= '0;
        end else if (wr_acc) begin
            if (hit(paddr, OFS_CTRL)) pwr_down_q <= pwdata[0];
            if (hit(paddr, OFS_ADDR)) addr_q <= pwdata[AW-1:0];
            if (hit(paddr, OFS_DATA)) data_q <= pwdata[7:0];
            if (hit(paddr, OFS_MASK)) mask_q <= pwdata[NIRQ-1:0];
        end
    end

    // command latch; a new command while one is queued is refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= OP_READ;
            setup_q <= 8'h00;
        end else if (wr_acc && hit(paddr, OFS_CMD) && !pend_q && st_q == ST_IDLE) begin
            op_q <= pwdata[1:0];
            setup_q <= pwdata[15:8];
        end
    end

    // wake-up counter after power-down release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= '0;
        end else if (!pins_q.rp_n) begin
            wake_q <= '0;
        end else if (wake_q != {CW{1'b1}}) begin
            wake_q <= wake_q + 1'b1;
        end
    end

    // pin sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            pins_q <= PINS_RST;
            pend_q <= 1'b0;
            second_q <= 1'b0;
            cnt_q <= '0;
            rdata_q <= 8'h00;
        end else begin
            pins_q.rp_n <= rp_d;
            if (wr_acc && hit(paddr, OFS_CMD) && !pend_q && st_q == ST_IDLE) begin
                pend_q <= 1'b1;
            end
            if (!rp_d || !pins_q.rp_n) begin
                // disabled flash: release every strobe
                st_q <= ST_IDLE;
                pins_q.ce_n <= 1'b1;
                pins_q.oe_n <= 1'b1;
                pins_q.we_n <= 1'b1;
                pins_q.dq_oe_n <= 1'b1;
                pend_q <= 1'b0;
                second_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        // wait for ready before any access
                        if (pend_q && rdy_s && wake_ok) begin
                            pend_q <= 1'b0;
                            second_q <= 1'b0;
                            st_q <= ST_SETUP;
                            pins_q.addr <= addr_q;
                            pins_q.ce_n <= 1'b0;
                            pins_q.dq_oe_n <= op_q == OP_READ;
                            pins_q.dq_o <= (op_q == OP_TWO) ? setup_q : data_q;
                        end
                    end
                    ST_SETUP: begin
                        st_q <= ST_STROBE;
                        cnt_q <= CW'(STROBE_CYC);
                        if (op_q == OP_READ) pins_q.oe_n <= 1'b0;
                        else pins_q.we_n <= 1'b0;
                    end
                    ST_STROBE: begin
                        cnt_q <= cnt_q - 1'b1;
                        if (cnt_q == CW'(1)) begin
                            st_q <= ST_HOLD;
                            pins_q.oe_n <= 1'b1;
                            pins_q.we_n <= 1'b1;
                            if (op_q == OP_READ) rdata_q <= dq_s;
                        end
                    end
                    ST_HOLD: begin
                        st_q <= ST_GAP;
                        pins_q.ce_n <= 1'b1;
                        pins_q.dq_oe_n <= 1'b1;
                    end
                    ST_GAP: begin
                        if (op_q == OP_TWO && !second_q) begin
                            second_q <= 1'b1;
                            st_q <= ST_SETUP;
                            pins_q.ce_n <= 1'b0;
                            pins_q.dq_oe_n <= 1'b0;
                            pins_q.dq_o <= data_q;
                        end else if (op_q == OP_READ) begin
                            st_q <= ST_IDLE;
                        end else begin
                            st_q <= ST_GUARD;
                            cnt_q <= CW'(GUARD_CYC);
                        end
                    end
                    ST_GUARD: begin
                        // give the flash time to pull ready_busy_n low
                        cnt_q <= cnt_q - 1'b1;
                        if (cnt_q == CW'(1)) st_q <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        if (rdy_s) st_q <= ST_IDLE;
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // events and sticky status, set wins over read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rdy_d1_q <= 1'b1;
        else rdy_d1_q <= rdy_s;
    end
    always_comb begin
        ev = '0;
        ev[IRQ_DONE] = pins_q.rp_n && rp_d && ((st_q == ST_WAIT && rdy_s) ||
            (st_q == ST_GAP && op_q == OP_READ));
        ev[IRQ_READY] = rdy_s && !rdy_d1_q;
        ev[IRQ_ABORT] = pins_q.rp_n && !rp_d && (st_q != ST_IDLE || pend_q);
        ev[IRQ_REJECT] = wr_acc && hit(paddr, OFS_CMD) && (pend_q || st_q != ST_IDLE);
    end
    // read clears only the bits that were reported
    assign kept = (rd_acc && hit(paddr, OFS_IRQ)) ? (stat_q & ~prdata_q[NIRQ-1:0]) : stat_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= kept | ev;
            irq_q <= |((kept | ev) & mask_q);
        end
    end

    assign pins = pins_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    a_we_with_ce: assert property (@(posedge pclk) disable iff (!presetn)
        !pins_q.we_n |-> !pins_q.ce_n)
        else $error("write strobe without chip select");
    a_rp_low_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !pins_q.rp_n |=> pins_q.ce_n && pins_q.we_n && pins_q.oe_n)
        else $error("strobes active in power-down");
    a_wake_write: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pins_q.we_n) |-> wake_q >= CW'(WAKE_W))
        else $error("write before wake delay");
    a_wake_read: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pins_q.oe_n) |-> wake_q >= CW'(WAKE_R))
        else $error("read before wake delay");
    a_no_contention: assert property (@(posedge pclk) disable iff (!presetn)
        !pins_q.oe_n |-> pins_q.we_n && pins_q.dq_oe_n && !pins_q.ce_n)
        else $error("bus driven while reading");
    a_two_step: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_GAP && op_q == OP_TWO && !second_q && rp_d && pins_q.rp_n
        |=> st_q == ST_SETUP && second_q && pins_q.dq_o == data_q)
        else $error("confirm write missing");
    a_busy_wait: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == ST_WAIT && !rdy_s && rp_d && pins_q.rp_n |=> st_q == ST_WAIT)
        else $error("left wait while busy");
    a_abort_flag: assert property (@(posedge pclk) disable iff (!presetn)
        pins_q.rp_n && !rp_d && st_q != ST_IDLE |=> stat_q[IRQ_ABORT] && st_q == ST_IDLE)
        else $error("abort not reported");
    a_rp_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !good_s |=> !pins_q.rp_n)
        else $error("power-down pin ignores supply");
endmodule : frspc_ctrl

/* verilog/frspc_pkg.sv */
/*
 * frspc_pkg: constants, types and register map for the flash pin controller.
 * Assumes a 50 MHz pclk; wake-up figures are plain defaults.
 */
package frspc_pkg;
    localparam int CLK_MHZ = 50;
    // times in ns
    localparam int STROBE_NS = 100;
    localparam int GUARD_NS = 200;
    localparam int WAKE_READ_NS = 1000;
    localparam int WAKE_WRITE_NS = 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GUARD_CYC = (GUARD_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_READ_CYC = (WAKE_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int AW = 20;
    localparam int CW = 16;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    // irq bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_ABORT = 2;
    localparam int IRQ_REJECT = 3;
    localparam int NIRQ = 4;
    // command op codes
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_TWO = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP, ST_GUARD, ST_WAIT
    } frspc_state_e;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rp_n;
        logic dq_oe_n;
        logic [AW-1:0] addr;
        logic [7:0] dq_o;
    } frspc_pins_s;
    localparam frspc_pins_s PINS_RST = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        rp_n: 1'b0, dq_oe_n: 1'b1, addr: '0, dq_o: 8'h00};
endpackage : frspc_pkg

/* verilog/frspc_sync.sv */
/*
 * frspc_sync: two-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous to pclk.
 */
`timescale 1ns/1ns
module frspc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : frspc_sync
